/* File: sat_bench.sv */
/* self-checking bench of the segment translation unit.
   assumes sat_pkg, sat_top and sat_monitor compiled before. */
`timescale 1ns/1ps
module sat_bench;
    import sat_pkg::*;
    logic        mclk = 0, rst_n = 0;           // clock, reset
    logic [5:0]  avs_address = 6'h0;            // bus address
    logic        avs_read = 0, avs_write = 0;   // bus strobes
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
    logic        avs_waitrequest, irq, req_valid = 0;
    sat_req_t    req = '0;                      // request
    sat_rsp_t    rsp;                           // answer
    logic        req_ready, rsp_valid, mem_rd, mem_ack = 0;
    logic [63:0] mem_addr, mem_rdata = 64'h0;   // table port
    logic [63:0] mem [logic [63:0]];            // table store
    int          err_total = 0, check_count = 0;
    always #12.5 mclk = ~mclk; // 40 MHz
    sat_top sat_top_inst (.mclk, .rst_n, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .irq,
        .req_valid, .req, .req_ready, .rsp_valid, .rsp, .mem_rd, .mem_addr,
        .mem_rdata, .mem_ack);
    // table memory: one word every second cycle, junk when idle
    always @(posedge mclk) begin
        mem_ack <= mem_rd && !mem_ack;
        mem_rdata <= (mem_rd && !mem_ack && mem.exists(mem_addr)) ?
            mem[mem_addr] : ~mem_rdata;
    end
    // present legacy descriptor, limit 0xffff
    function automatic logic [63:0] dsc(logic [31:0] b, logic [3:0] t,
                                        logic [1:0] d);
        return {b[31:24], 8'h00, 1'b1, d, 1'b1, t, b[23:0], 16'hffff};
    endfunction
    task chk(input logic [63:0] g, input logic [63:0] e);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task bw(input logic [5:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= 1;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        avs_write <= 0;
        @(posedge mclk);
    endtask
    task br(input logic [5:0] a);
        avs_address <= a;
        avs_read <= 1;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 0;
        @(posedge mclk);
    endtask
    // translate and compare address, fault flag, error code
    task xl(input logic [15:0] s, input logic [63:0] o, input logic w,
            input logic f, input logic [63:0] el, input logic g,
            input logic [15:0] ee);
        int n;
        req <= {s, o, w, f};
        req_valid <= 1;
        do @(posedge mclk); while (req_ready !== 1'b1);
        req_valid <= 0;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (rsp_valid !== 1'b1 && n < 50);
        chk(rsp_valid, 1'b1);
        chk(rsp.linear, el);
        chk(rsp.gp, g);
        chk(rsp.err, ee);
    endtask
    task t_real;
        br(SAT_OFS_CTRL);
        chk(rd, 32'h0);
        br(6'h38);
        chk(rd, 32'h0);
        xl(16'h1234, 64'h10, 0, 0, 64'h12350, 0, 16'h0);
        $display("real mode done");
    endtask
    task t_prot;
        mem[64'h1010] = dsc(32'h00400000, 4'h2, 2'h0);
        mem[64'h1018] = dsc(32'h00600000, 4'h2, 2'h0);
        mem[64'h1020] = dsc(32'h00500000, 4'ha, 2'h0);
        bw(SAT_OFS_GDT_LO, 32'h1000);
        bw(SAT_OFS_GDT_LIM, 32'hff);
        bw(SAT_OFS_CTRL, 32'h1);
        xl(16'h0010, 64'h20, 0, 0, 64'h400020, 0, 16'h0);
        xl(16'h0010, 64'h10000, 0, 0, 64'h0, 1, 16'h0);
        xl(16'h0100, 64'h0, 0, 0, 64'h0, 1, 16'h0100);
        xl(16'h0020, 64'h0, 1, 0, 64'h0, 1, 16'h0020);
        bw(SAT_OFS_CTRL, 32'hd);
        xl(16'h001b, 64'h4, 0, 0, 64'h0, 1, 16'h0018);
        br(SAT_OFS_ERR);
        chk(rd, 32'h18);
        xl(16'h0003, 64'h0, 0, 0, 64'h0, 1, 16'h0);
        br(SAT_OFS_STATUS);
        chk(rd, 32'h3);
        chk(irq, 1'b0);
        bw(SAT_OFS_IRQ_EN, 32'h2);
        @(posedge mclk);
        chk(irq, 1'b1);
        bw(SAT_OFS_CLEAR, 32'h3);
        @(posedge mclk);
        chk(irq, 1'b0);
        $display("protected mode done");
    endtask
    task t_fetch;
        bw(SAT_OFS_CTRL, 32'h1);
        bw(SAT_OFS_CODE, 32'h20);
        bw(SAT_OFS_IP_LO, 32'h44);
        xl(16'h0, 64'h0, 0, 1, 64'h500044, 0, 16'h0);
        $display("code fetch done");
    endtask
    task t_wide;
        mem[64'h1_0000_2010] = dsc(32'h00400000, 4'h2, 2'h0);
        mem[64'h1_0000_2018] = 64'h5;
        mem[64'h2008] = dsc(32'h00300000, 4'h2, 2'h0);
        bw(SAT_OFS_LDT_LO, 32'h2000);
        bw(SAT_OFS_LDT_HI, 32'h1);
        bw(SAT_OFS_LDT_LIM, 32'hff);
        bw(SAT_OFS_CTRL, 32'h3);
        br(SAT_OFS_LDT_HI);
        chk(rd, 32'h1);
        xl(16'h000c, 64'h8, 0, 0, 64'h5_0040_0008, 0, 16'h0);
        bw(SAT_OFS_LDT_HI, 32'h0);
        bw(SAT_OFS_CTRL, 32'h2);
        xl(16'h000c, 64'h8, 0, 0, 64'h300008, 0, 16'h0);
        $display("wide entries done");
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // main sequence after six reset cycles
    initial begin
        repeat (6) @(posedge mclk);
        rst_n <= 1;
        @(posedge mclk);
        t_real;
        t_prot;
        t_fetch;
        t_wide;
        finish_test;
    end
    // watchdog against a hung handshake
    initial begin
        #(25 * 4000);
        err_total++;
        finish_test;
    end
endmodule

/* File: sat_desc_dec.sv */
/*
 * descriptor field decoder, purely combinational.
 * assumes lo/hi hold the first and second 8-byte words of an entry.
 */
`timescale 1ns/1ps
module sat_desc_dec (
    input  wire logic [63:0]       lo,   // first descriptor word
    input  wire logic [63:0]       hi,   // second word, wide only
    input  wire logic              wide, // 16-byte entry
    output sat_pkg::sat_desc_t     desc  // decoded fields
);
    import sat_pkg::*;

    logic [19:0] raw_lim; // 20-bit limit field

    // unpack base, rights, type and usage
    always_comb begin
        raw_lim = {lo[SAT_D_LIM1 +: 4], lo[SAT_D_LIM0 +: 16]};
        desc.base[31:0] = {lo[SAT_D_BASE1 +: 8], lo[SAT_D_BASE0 +: 24]};
        // wide entries carry the upper base half
        desc.base[63:32] = wide ? hi[31:0] : 32'h0;
        // page granularity scales the limit
        desc.limit = lo[SAT_D_G] ? {raw_lim, 12'hfff}
                                 : {12'h0, raw_lim};
        desc.dpl = lo[SAT_D_DPL +: 2];
        desc.present = lo[SAT_D_P];
        desc.sys = ~lo[SAT_D_S];
        desc.code = lo[SAT_D_TYPE + 3];
        desc.rw = lo[SAT_D_TYPE + 1];
    end

endmodule

/* File: sat_monitor.sv */
/* port checker of the segment translation unit.
   assumes one mclk domain, rst_n synchronous low. */
`timescale 1ns/1ps
module sat_monitor #(
    parameter int REG_AW = 6 // bus address width
) (
    input wire logic              mclk,            // core clock
    input wire logic              rst_n,           // sync reset
    input wire logic [REG_AW-1:0] avs_address,     // byte address
    input wire logic              avs_read,        // read request
    input wire logic              avs_write,       // write request
    input wire logic [31:0]       avs_writedata,   // write data
    input wire logic [31:0]       avs_readdata,    // read data
    input wire logic              avs_waitrequest, // stall
    input wire logic              irq,             // interrupt
    input wire logic              req_valid,       // request valid
    input wire sat_pkg::sat_req_t req,             // request
    input wire logic              req_ready,       // unit idle
    input wire logic              rsp_valid,       // answer pulse
    input wire sat_pkg::sat_rsp_t rsp,             // answer
    input wire logic              mem_rd,          // table read
    input wire logic [63:0]       mem_addr,        // table address
    input wire logic [63:0]       mem_rdata,       // table word
    input wire logic              mem_ack          // word valid
);
    import sat_pkg::*;
    // one clock domain, checks idle in reset
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    chk_wait_one: assert property ((avs_read || avs_write)
        && avs_waitrequest |=> !avs_waitrequest) else $error("bus late");
    chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("wait low too long");
    chk_reset_idle: assert property ($rose(rst_n) |->
        req_ready && !mem_rd && !irq && !rsp_valid) else $error("reset");
    chk_fetch_cause: assert property ($rose(mem_rd) |->
        $past(req_valid && req_ready)) else $error("stray table read");
    chk_hold_req: assert property (mem_rd && !mem_ack |=>
        mem_rd && $stable(mem_addr)) else $error("read not held");
    chk_wide_next: assert property (mem_rd && mem_ack |=>
        !mem_rd || mem_addr == $past(mem_addr) + 64'h8)
        else $error("second word address");
    chk_answer_time: assert property (mem_rd && mem_ack ##1
        !mem_rd |=> rsp_valid) else $error("answer late");
    chk_gp_block: assert property (rsp_valid && rsp.gp |->
        rsp.linear == 64'h0) else $error("fault leaks address");
    chk_err_code: assert property (rsp_valid && rsp.gp |->
        rsp.err[1:0] == 2'h0) else $error("error code form");
    chk_ready_back: assert property (rsp_valid |-> req_ready)
        else $error("idle not back");
endmodule
bind sat_top sat_monitor #(.REG_AW(REG_AW)) sat_monitor_inst (.mclk,
    .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .irq, .req_valid, .req, .req_ready,
    .rsp_valid, .rsp, .mem_rd, .mem_addr, .mem_rdata, .mem_ack);

/* File: sat_pkg.sv */
/*
 * shared constants and types of the segment address translation unit:
 * register offsets, reset values, field positions, modes, carriers.
 * assumes a single 40 MHz core clock and a 32-bit avalon-mm slave.
 */
package sat_pkg;

    // operating modes, real-address mode is the reset mode
    typedef enum logic [1:0] {
        SAT_REAL,
        SAT_PROT,
        SAT_COMPAT,
        SAT_LONG
    } sat_mode_t;

    // register byte offsets
    localparam logic [5:0] SAT_OFS_CTRL    = 6'h00;
    localparam logic [5:0] SAT_OFS_GDT_LO  = 6'h04;
    localparam logic [5:0] SAT_OFS_GDT_HI  = 6'h08;
    localparam logic [5:0] SAT_OFS_GDT_LIM = 6'h0c;
    localparam logic [5:0] SAT_OFS_LDT_LO  = 6'h10;
    localparam logic [5:0] SAT_OFS_LDT_HI  = 6'h14;
    localparam logic [5:0] SAT_OFS_LDT_LIM = 6'h18;
    localparam logic [5:0] SAT_OFS_CODE    = 6'h1c;
    localparam logic [5:0] SAT_OFS_IP_LO   = 6'h20;
    localparam logic [5:0] SAT_OFS_IP_HI   = 6'h24;
    localparam logic [5:0] SAT_OFS_STATUS  = 6'h28;
    localparam logic [5:0] SAT_OFS_CLEAR   = 6'h2c;
    localparam logic [5:0] SAT_OFS_IRQ_EN  = 6'h30;
    localparam logic [5:0] SAT_OFS_ERR     = 6'h34;

    // control register fields
    localparam int SAT_CTRL_MODE_LSB = 0;
    localparam int SAT_CTRL_CPL_LSB  = 2;

    // event bits of status, clear and enable
    localparam int SAT_EV_DONE = 0;
    localparam int SAT_EV_GP   = 1;
    localparam int SAT_EV_W    = 2;

    // reset values
    localparam sat_mode_t   SAT_RST_MODE = SAT_REAL;
    localparam logic [1:0]  SAT_RST_CPL  = 2'h0;
    localparam logic [63:0] SAT_RST_BASE = 64'h0;
    localparam logic [31:0] SAT_RST_LIM  = 32'h0;
    localparam logic [15:0] SAT_RST_SEL  = 16'h0;
    localparam logic [63:0] SAT_RST_IP   = 64'h0;
    localparam logic [1:0]  SAT_RST_EV   = 2'h0;

    // selector fields
    localparam int SAT_SEL_TI      = 2;
    localparam int SAT_SEL_IDX_LSB = 3;

    // descriptor fields, legacy 8-byte layout
    localparam int SAT_D_LIM0  = 0;
    localparam int SAT_D_BASE0 = 16;
    localparam int SAT_D_TYPE  = 40;
    localparam int SAT_D_S     = 44;
    localparam int SAT_D_DPL   = 45;
    localparam int SAT_D_P     = 47;
    localparam int SAT_D_LIM1  = 48;
    localparam int SAT_D_G     = 55;
    localparam int SAT_D_BASE1 = 56;

    // shift counts: 8-byte legacy and 16-byte wide entries, selector times 16 in real mode
    localparam int SAT_LEG_SHIFT  = 3;
    localparam int SAT_WIDE_SHIFT = 4;
    localparam int SAT_REAL_SHIFT = 4;

    // error code pushed when no accurate code can be given
    localparam logic [15:0] SAT_ERR_NONE = 16'h0;

    // translation request
    typedef struct packed {
        logic [15:0] sel;     // segment selector
        logic [63:0] offset;  // byte offset in segment
        logic        write;   // data write
        logic        fetch;   // instruction fetch via code regs
    } sat_req_t;

    // translation answer
    typedef struct packed {
        logic [63:0] linear;  // linear byte address
        logic        gp;      // general protection fault
        logic [15:0] err;     // fault error code
    } sat_rsp_t;

    // decoded descriptor
    typedef struct packed {
        logic [63:0] base;
        logic [31:0] limit;   // byte limit after granularity
        logic [1:0]  dpl;
        logic        present;
        logic        code;
        logic        rw;      // writable data or readable code
        logic        sys;     // system descriptor
    } sat_desc_t;

endpackage

/* File: sat_top.sv */
/*
 * segment address translation unit with avalon-mm register slave.
 * assumes descriptor memory on mclk answering mem_rd with mem_ack,
 * and one outstanding translation at a time.
 */
`timescale 1ns/1ps
module sat_top #(
    parameter int REG_AW = 6 // avalon byte address width
) (
    input  wire logic              mclk,            // core clock
    input  wire logic              rst_n,           // sync reset
    input  wire logic [REG_AW-1:0] avs_address,     // byte address
    input  wire logic              avs_read,        // read request
    input  wire logic              avs_write,       // write request
    input  wire logic [31:0]       avs_writedata,   // write data
    output logic      [31:0]       avs_readdata,    // read data
    output logic                   avs_waitrequest, // stall
    output logic                   irq,             // level interrupt
    input  wire logic              req_valid,       // request valid
    input  wire sat_pkg::sat_req_t req,             // request
    output logic                   req_ready,       // unit idle
    output logic                   rsp_valid,       // answer pulse
    output sat_pkg::sat_rsp_t      rsp,             // answer
    output logic                   mem_rd,          // descriptor read
    output logic      [63:0]       mem_addr,        // descriptor addr
    input  wire logic [63:0]       mem_rdata,       // descriptor word
    input  wire logic              mem_ack          // word valid
);
    import sat_pkg::*;

    // elaboration check: the register map needs six address bits
    if (REG_AW < 6) begin : g_aw_check
        $error("REG_AW too small for register map");
    end

    typedef enum logic [1:0] {S_IDLE, S_LO, S_HI, S_CHECK} sat_state_t;

    sat_mode_t      mode;       // operating mode
    logic [1:0]     current_privilege_level;        // current_privilege_level
    logic [63:0]    gdt_base;   // global_table_base_reg base
    logic [31:0]    gdt_limit;  // global table byte limit
    logic [63:0]    ldt_base;   // local_table_reg base
    logic [31:0]    ldt_limit;  // local table byte limit
    logic [15:0]    code_sel;   // code segment selector
    logic [63:0]    ip;         // instruction_pointer_reg
    logic [1:0]     status;     // sticky events
    logic [1:0]     irq_en;     // event enables
    logic [15:0]    last_err;   // last fault error code
    sat_state_t     state;      // translation state
    logic [15:0]    cur_sel;    // latched selector
    logic [63:0]    cur_off;    // latched offset
    logic           cur_wr;     // latched write
    logic           cur_fetch;  // latched fetch
    logic           cur_wide;   // 16-byte entry
    logic [63:0]    desc_lo;    // first descriptor word
    logic [63:0]    desc_hi;    // second descriptor word
    sat_desc_t      dsc;        // decoded descriptor
    logic           bus_wr;     // write taken this edge
    logic [1:0]     ev_set;     // events raised this edge
    logic [1:0]     next_status;
    sat_req_t       in;         // effective request
    logic           in_ti;      // table flag
    logic           in_wide;    // entry stride 16
    logic [63:0]    in_tbase;   // selected table base
    logic [31:0]    in_tlim;    // selected table limit
    logic [63:0]    in_eofs;    // entry byte offset
    logic [63:0]    in_eend;    // last byte of entry
    logic [1:0]     eff_priv;   // max of cpl and rpl
    logic           chk_fail;   // rights check failed
    logic           lim_fail;   // offset past limit
    logic [63:0]    chk_lin;    // linear from descriptor

    // protection error code: selector without the privilege bits
    function automatic logic [15:0] sel_err(input logic [15:0] s);
        sel_err = {s[15:2], 2'b00};
    endfunction

    // legacy modes keep a 32-bit address
    function automatic logic [63:0] fit(input sat_mode_t m,
                                        input logic [63:0] a);
        fit = (m == SAT_LONG) ? a : {32'h0, a[31:0]};
    endfunction

    sat_desc_dec u_dec (
        .lo   (desc_lo),
        .hi   (desc_hi),
        .wide (cur_wide),
        .desc (dsc)
    );

    // bus write takes effect where the master sees waitrequest low
    assign bus_wr = avs_write && !avs_waitrequest;

    // avalon handshake: one wait cycle, then a one-cycle answer
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0;
        end else if ((avs_read || avs_write) && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
            avs_readdata <= avs_read ? reg_read(avs_address) : 32'h0;
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    // register read mux, unmapped and write-only read as zero
    function automatic logic [31:0] reg_read(input logic [REG_AW-1:0] a);
        reg_read = 32'h0;
        case (a[5:0])
            SAT_OFS_CTRL:    reg_read = {28'h0, current_privilege_level, mode};
            SAT_OFS_GDT_LO:  reg_read = gdt_base[31:0];
            SAT_OFS_GDT_HI:  reg_read = gdt_base[63:32];
            SAT_OFS_GDT_LIM: reg_read = gdt_limit;
            SAT_OFS_LDT_LO:  reg_read = ldt_base[31:0];
            SAT_OFS_LDT_HI:  reg_read = ldt_base[63:32];
            SAT_OFS_LDT_LIM: reg_read = ldt_limit;
            SAT_OFS_CODE:    reg_read = {16'h0, code_sel};
            SAT_OFS_IP_LO:   reg_read = ip[31:0];
            SAT_OFS_IP_HI:   reg_read = ip[63:32];
            SAT_OFS_STATUS:  reg_read = {30'h0, status};
            SAT_OFS_IRQ_EN:  reg_read = {30'h0, irq_en};
            SAT_OFS_ERR:     reg_read = {16'h0, last_err};
            default:         reg_read = 32'h0;
        endcase
        if (a[REG_AW-1:0] > REG_AW'(SAT_OFS_ERR)) reg_read = 32'h0;
    endfunction

    // mode and privilege: real mode after reset, software moves on
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            mode <= SAT_RST_MODE;
            current_privilege_level <= SAT_RST_CPL;
        end else if (bus_wr && avs_address == REG_AW'(SAT_OFS_CTRL)) begin
            mode <= sat_mode_t'(avs_writedata[SAT_CTRL_MODE_LSB +: 2]);
            current_privilege_level <= avs_writedata[SAT_CTRL_CPL_LSB +: 2];
        end
    end

    // table registers, full 64-bit base storage and 32-bit limits
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            gdt_base <= SAT_RST_BASE;
            gdt_limit <= SAT_RST_LIM;
            ldt_base <= SAT_RST_BASE;
            ldt_limit <= SAT_RST_LIM;
        end else if (bus_wr) begin
            case (avs_address[5:0])
                SAT_OFS_GDT_LO:  gdt_base[31:0] <= avs_writedata;
                SAT_OFS_GDT_HI:  gdt_base[63:32] <= avs_writedata;
                SAT_OFS_GDT_LIM: gdt_limit <= avs_writedata;
                SAT_OFS_LDT_LO:  ldt_base[31:0] <= avs_writedata;
                SAT_OFS_LDT_HI:  ldt_base[63:32] <= avs_writedata;
                SAT_OFS_LDT_LIM: ldt_limit <= avs_writedata;
                default: ;
            endcase
        end
    end

    // code selector and instruction pointer
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            code_sel <= SAT_RST_SEL;
            ip <= SAT_RST_IP;
        end else if (bus_wr) begin
            case (avs_address[5:0])
                SAT_OFS_CODE:  code_sel <= avs_writedata[15:0];
                SAT_OFS_IP_LO: ip[31:0] <= avs_writedata;
                SAT_OFS_IP_HI: ip[63:32] <= avs_writedata;
                default: ;
            endcase
        end
    end

    // request decode: fetches substitute code regs
    always_comb begin
        in = req;
        if (req.fetch) begin
            in.sel = code_sel;
            in.offset = ip;
            in.write = 1'b0;
        end
        // selector: index, table flag, requested rights
        in_ti = in.sel[SAT_SEL_TI];
        // wide local entries only in 64-bit sub-mode
        in_wide = in_ti && (mode == SAT_LONG);
        // table from the global or local base register
        in_tbase = fit(mode, in_ti ? ldt_base : gdt_base);
        in_tlim = in_ti ? ldt_limit : gdt_limit;
        in_eofs = {51'h0, in.sel[15:SAT_SEL_IDX_LSB]}
                  << (in_wide ? SAT_WIDE_SHIFT : SAT_LEG_SHIFT);
        in_eend = in_eofs + (in_wide ? 64'hf : 64'h7);
    end

    // descriptor checks: privilege, type, presence, limit
    always_comb begin
        eff_priv = (cur_sel[1:0] > current_privilege_level) ? cur_sel[1:0] : current_privilege_level;
        // segment must be reachable from current privilege
        chk_fail = !dsc.present || dsc.sys;
        if (cur_fetch) begin
            chk_fail = chk_fail || !dsc.code || dsc.dpl != current_privilege_level;
        end else begin
            chk_fail = chk_fail || eff_priv > dsc.dpl;
            chk_fail = chk_fail || (cur_wr && (dsc.code || !dsc.rw));
            chk_fail = chk_fail || (!cur_wr && dsc.code && !dsc.rw);
        end
        lim_fail = (mode != SAT_LONG) && cur_off > {32'h0, dsc.limit};
        // linear is descriptor base plus byte offset
        chk_lin = fit(mode, dsc.base + cur_off);
    end

    // translation sequence through descriptor tables
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state <= S_IDLE;
            req_ready <= 1'b1;
            rsp_valid <= 1'b0;
            rsp <= '0;
            mem_rd <= 1'b0;
            mem_addr <= 64'h0;
            cur_sel <= 16'h0;
            cur_off <= 64'h0;
            cur_wr <= 1'b0;
            cur_fetch <= 1'b0;
            cur_wide <= 1'b0;
            desc_lo <= 64'h0;
            desc_hi <= 64'h0;
        end else begin
            rsp_valid <= 1'b0;
            unique case (state)
                S_IDLE: begin
                    if (req_valid && req_ready) begin
                        cur_sel <= in.sel;
                        cur_off <= fit(mode, in.offset);
                        cur_wr <= in.write;
                        cur_fetch <= req.fetch;
                        cur_wide <= in_wide;
                        desc_hi <= 64'h0;
                        if (mode == SAT_REAL) begin
                            // real mode: selector times 16 plus the low 16 offset bits
                            rsp_valid <= 1'b1;
                            rsp.gp <= 1'b0;
                            rsp.err <= SAT_ERR_NONE;
                            rsp.linear <= {44'h0, in.sel,
                                           SAT_REAL_SHIFT'(0)}
                                          + {48'h0, in.offset[15:0]};
                        end else if (in.sel[15:2] == 14'h0) begin
                            // null selector: no accurate code
                            rsp_valid <= 1'b1;
                            rsp.gp <= 1'b1;
                            rsp.err <= SAT_ERR_NONE;
                            rsp.linear <= 64'h0;
                        end else if (in_eend > {32'h0, in_tlim}) begin
                            // entry outside the table
                            rsp_valid <= 1'b1;
                            rsp.gp <= 1'b1;
                            rsp.err <= sel_err(in.sel);
                            rsp.linear <= 64'h0;
                        end else begin
                            mem_rd <= 1'b1;
                            mem_addr <= fit(mode, in_tbase + in_eofs);
                            req_ready <= 1'b0;
                            state <= S_LO;
                        end
                    end
                end
                S_LO: begin
                    if (mem_ack) begin
                        desc_lo <= mem_rdata;
                        if (cur_wide) begin
                            // second half of a 16-byte entry
                            mem_addr <= mem_addr + 64'h8;
                            state <= S_HI;
                        end else begin
                            mem_rd <= 1'b0;
                            state <= S_CHECK;
                        end
                    end
                end
                S_HI: begin
                    if (mem_ack) begin
                        desc_hi <= mem_rdata;
                        mem_rd <= 1'b0;
                        state <= S_CHECK;
                    end
                end
                S_CHECK: begin
                    rsp_valid <= 1'b1;
                    req_ready <= 1'b1;
                    state <= S_IDLE;
                    if (chk_fail) begin
                        // blocked, no address given
                        rsp.gp <= 1'b1;
                        rsp.err <= sel_err(cur_sel);
                        rsp.linear <= 64'h0;
                    end else if (lim_fail) begin
                        // limit faults carry a zero code
                        rsp.gp <= 1'b1;
                        rsp.err <= SAT_ERR_NONE;
                        rsp.linear <= 64'h0;
                    end else begin
                        rsp.gp <= 1'b0;
                        rsp.err <= SAT_ERR_NONE;
                        rsp.linear <= chk_lin;
                    end
                end
            endcase
        end
    end

    // events raised by the answer about to be driven
    always_comb begin
        ev_set = 2'h0;
        if (state == S_CHECK) begin
            ev_set[SAT_EV_DONE] = 1'b1;
            ev_set[SAT_EV_GP] = chk_fail || lim_fail;
        end else if (state == S_IDLE && req_valid && req_ready) begin
            ev_set[SAT_EV_DONE] = (mode == SAT_REAL)
                                  || in.sel[15:2] == 14'h0
                                  || in_eend > {32'h0, in_tlim};
            ev_set[SAT_EV_GP] = (mode != SAT_REAL)
                                && (in.sel[15:2] == 14'h0
                                    || in_eend > {32'h0, in_tlim});
        end
        next_status = status;
        if (bus_wr && avs_address == REG_AW'(SAT_OFS_CLEAR)) begin
            next_status = status & ~avs_writedata[SAT_EV_W-1:0];
        end
        // set wins over a clear in the same cycle
        next_status = next_status | ev_set;
    end

    // sticky status, enables, last error and interrupt line
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            status <= SAT_RST_EV;
            irq_en <= SAT_RST_EV;
            last_err <= SAT_ERR_NONE;
            irq <= 1'b0;
        end else begin
            status <= next_status;
            if (bus_wr && avs_address == REG_AW'(SAT_OFS_IRQ_EN)) begin
                irq_en <= avs_writedata[SAT_EV_W-1:0];
            end
            if (state == S_CHECK && chk_fail) begin
                last_err <= sel_err(cur_sel);
            end else if (ev_set[SAT_EV_GP]) begin
                last_err <= (state == S_IDLE && in.sel[15:2] != 14'h0)
                            ? sel_err(in.sel) : SAT_ERR_NONE;
            end
            irq <= |(next_status & irq_en);
        end
    end

endmodule
